// ---- asd_pkg.sv ----
package asd_pkg;

  // Clock rate
  localparam int unsigned CLK_HZ = 20_000_000;

  // Register indexes; byte address is four times the index
  localparam logic [5:0] IDX_ACC_STATE = 6'h19;
  localparam logic [5:0] IDX_PROBE_SET = 6'h1a;
  localparam logic [5:0] IDX_SPARE     = 6'h1b;
  localparam logic [5:0] IDX_POWER     = 6'h1d;
  localparam logic [5:0] IDX_STATUS    = 6'h30;
  localparam logic [5:0] IDX_PROBE_AVG = 6'h31;

  // Field positions
  localparam int unsigned ACC_OVERRIDE_BIT = 7;
  localparam int unsigned SET_DEB_BIT      = 7;
  localparam int unsigned SET_REP_LSB      = 4;
  localparam int unsigned SET_PW_LSB       = 2;
  localparam int unsigned SET_AMP_LSB      = 0;
  localparam int unsigned PWR_CTRL_BIT     = 7;
  localparam int unsigned STAT_JACK_BIT    = 7;
  localparam int unsigned STAT_BUSY_BIT    = 6;

  // Values after reset, and the settings write mask
  localparam logic       ACC_OVERRIDE_RST = 1'h1;
  localparam logic [6:0] ACC_CODE_RST     = 7'h00;
  localparam logic [7:0] SET_RST          = 8'h15;
  localparam logic [7:0] SET_WR_MASK      = 8'hbf;
  localparam logic       PWR_CTRL_RST     = 1'h0;

  // Debounce times in ms and their cycle counts
  localparam int unsigned DEB_INS_FAST_MS  = 3;
  localparam int unsigned DEB_REM_FAST_MS  = 12;
  localparam int unsigned DEB_INS_SLOW_MS  = 20;
  localparam int unsigned DEB_REM_SLOW_MS  = 80;
  localparam int unsigned DEB_INS_FAST_CYC = DEB_INS_FAST_MS * (CLK_HZ / 1000);
  localparam int unsigned DEB_REM_FAST_CYC = DEB_REM_FAST_MS * (CLK_HZ / 1000);
  localparam int unsigned DEB_INS_SLOW_CYC = DEB_INS_SLOW_MS * (CLK_HZ / 1000);
  localparam int unsigned DEB_REM_SLOW_CYC = DEB_REM_SLOW_MS * (CLK_HZ / 1000);
  localparam int unsigned DEB_CNT_W        = 21;

  // Probe pulse widths in us and their cycle counts
  localparam int unsigned PW_A_US  = 50;
  localparam int unsigned PW_B_US  = 25;
  localparam int unsigned PW_C_US  = 100;
  localparam int unsigned PW_D_US  = 200;
  localparam logic [11:0] PW_A_CYC = 12'(PW_A_US * (CLK_HZ / 1_000_000));
  localparam logic [11:0] PW_B_CYC = 12'(PW_B_US * (CLK_HZ / 1_000_000));
  localparam logic [11:0] PW_C_CYC = 12'(PW_C_US * (CLK_HZ / 1_000_000));
  localparam logic [11:0] PW_D_CYC = 12'(PW_D_US * (CLK_HZ / 1_000_000));

  // Accessory codes
  localparam logic [6:0] CODE_NONE           = 7'h00;
  localparam logic [6:0] CODE_HS_STEREO      = 7'h01;
  localparam logic [6:0] CODE_HS_STEREO_SWAP = 7'h02;
  localparam logic [6:0] CODE_MONO_BASE      = 7'h0a;
  localparam logic [6:0] CODE_HP_STEREO      = 7'h10;
  localparam logic [6:0] CODE_HP_LEFT        = 7'h11;
  localparam logic [6:0] CODE_HP_RIGHT       = 7'h12;
  localparam logic [6:0] CODE_LO_STEREO      = 7'h1a;
  localparam logic [6:0] CODE_LO_RIGHT       = 7'h1b;
  localparam logic [6:0] CODE_LO_LEFT        = 7'h1c;
  localparam logic [6:0] CODE_UNSUPPORTED    = 7'h1f;

  // Averaged probe result at or above this is a line-out load
  localparam logic [7:0] LINEOUT_THRESH = 8'h80;

  // Contact kind from the front end; SPECIAL is mic on ring2/sleeve, tied-to-tip on ring1
  typedef enum logic [1:0] {
    KIND_FLOAT   = 2'b00,
    KIND_GROUND  = 2'b01,
    KIND_LOAD    = 2'b10,
    KIND_SPECIAL = 2'b11
  } asd_kind_t;

  typedef enum logic [1:0] {
    DET_IDLE     = 2'b00,
    DET_PROBE    = 2'b01,
    DET_CLASSIFY = 2'b10
  } asd_det_state_t;

  typedef enum logic {
    PRB_IDLE  = 1'b0,
    PRB_PULSE = 1'b1
  } asd_probe_state_t;

endpackage

// ---- asd_probe_if.sv ----
`timescale 1ns/100ps
interface asd_probe_if;
  logic       start;
  logic [1:0] repeatSel;
  logic [1:0] widthSel;
  logic       busy;
  logic       done;
  logic [7:0] average;

  modport ctrl (output start, output repeatSel, output widthSel,
                input busy, input done, input average);
  modport seq  (input start, input repeatSel, input widthSel,
                output busy, output done, output average);
endinterface

// ---- asd_debounce.sv ----
`timescale 1ns/100ps
module asd_debounce
  import asd_pkg::*;
#(
  parameter logic [DEB_CNT_W-1:0] INS_FAST = DEB_CNT_W'(DEB_INS_FAST_CYC),
  parameter logic [DEB_CNT_W-1:0] REM_FAST = DEB_CNT_W'(DEB_REM_FAST_CYC),
  parameter logic [DEB_CNT_W-1:0] INS_SLOW = DEB_CNT_W'(DEB_INS_SLOW_CYC),
  parameter logic [DEB_CNT_W-1:0] REM_SLOW = DEB_CNT_W'(DEB_REM_SLOW_CYC)
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Comparator level, already synchronised
  input  wire logic rawLevel,
  input  wire logic slowSel,
  // Debounced level
  output logic      stableLevel
);

  logic [DEB_CNT_W-1:0] count_reg;
  logic [DEB_CNT_W-1:0] limit;
  logic                 level_reg;

  // Rising is an insertion, falling a removal
  always_comb begin
    if (rawLevel) begin
      limit = slowSel ? INS_SLOW : INS_FAST;
    end else begin
      limit = slowSel ? REM_SLOW : REM_FAST;
    end
  end

  // Any bounce back to the stable level restarts the wait
  always_ff @(posedge clk) begin
    if (reset) begin
      count_reg <= '0;
      level_reg <= 1'b0;
    end else if (rawLevel == level_reg) begin
      count_reg <= '0;
    end else if (count_reg >= limit - 21'h1) begin
      count_reg <= '0;
      level_reg <= rawLevel;
    end else begin
      count_reg <= count_reg + 21'h1;
    end
  end

  assign stableLevel = level_reg;

endmodule

// ---- asd_probe_seq.sv ----
`timescale 1ns/100ps
module asd_probe_seq
  import asd_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // Control side
  asd_probe_if.seq        probe,
  // Front end
  input  wire logic [7:0] probeSample,
  output logic            probePulse
);

  asd_probe_state_t state_reg;
  logic [11:0]      widthCnt_reg;
  logic [11:0]      widthLim_reg;
  logic [3:0]       runCnt_reg;
  logic [1:0]       rep_reg;
  logic [10:0]      sum_reg;
  logic [10:0]      sumNext;
  logic [7:0]       avg_reg;
  logic             done_reg;
  logic             pulseEnd;
  logic             lastEnd;

  // Last pulse ends when run count equals 2**repeat - 1
  assign pulseEnd = (state_reg == PRB_PULSE) && (widthCnt_reg == widthLim_reg - 12'h1);
  assign lastEnd  = pulseEnd && (runCnt_reg == (4'h1 << rep_reg) - 4'h1);
  assign sumNext  = sum_reg + {3'h0, probeSample};

  // Sequencer state
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= PRB_IDLE;
    end else begin
      case (state_reg)
        PRB_IDLE:  if (probe.start) state_reg <= PRB_PULSE;
        PRB_PULSE: if (lastEnd) state_reg <= PRB_IDLE;
        default:   state_reg <= PRB_IDLE;
      endcase
    end
  end

  // Latched at start; a mid-run write cannot skew the average
  always_ff @(posedge clk) begin
    if (reset) begin
      rep_reg      <= 2'h0;
      widthLim_reg <= PW_B_CYC;
    end else if (state_reg == PRB_IDLE && probe.start) begin
      rep_reg <= probe.repeatSel;
      case (probe.widthSel)
        2'h0:    widthLim_reg <= PW_A_CYC;
        2'h1:    widthLim_reg <= PW_B_CYC;
        2'h2:    widthLim_reg <= PW_C_CYC;
        default: widthLim_reg <= PW_D_CYC;
      endcase
    end
  end

  // Width and run counters
  always_ff @(posedge clk) begin
    if (reset || state_reg == PRB_IDLE) begin
      widthCnt_reg <= 12'h0;
      runCnt_reg   <= 4'h0;
    end else if (pulseEnd) begin
      widthCnt_reg <= 12'h0;
      runCnt_reg   <= runCnt_reg + 4'h1;
    end else begin
      widthCnt_reg <= widthCnt_reg + 12'h1;
    end
  end

  // Power-of-two runs make the average a shift
  always_ff @(posedge clk) begin
    if (reset) begin
      sum_reg  <= 11'h0;
      avg_reg  <= 8'h0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= lastEnd;
      if (state_reg == PRB_IDLE) begin
        sum_reg <= 11'h0;
      end else if (pulseEnd) begin
        sum_reg <= sumNext;
      end
      if (lastEnd) begin
        avg_reg <= 8'(sumNext >> rep_reg);
      end
    end
  end

  assign probePulse    = (state_reg == PRB_PULSE);
  assign probe.busy    = (state_reg == PRB_PULSE);
  assign probe.done    = done_reg;
  assign probe.average = avg_reg;

endmodule

// ---- asd_top.sv ----
// Operation
// - Override bit clear: load follows the code the host wrote.
// - Override bit set: code field shows the detection result.
// - Codes: 0x00 nothing, 0x0A-0x0F mono headsets, 0x10-0x12 headphones.
// - Stereo headset 0x01 with mic on sleeve, 0x02 with mic on ring2.
// - Line-out 0x1A-0x1C by channel loads; both channels missing is 0x1F.
// - Debounce select: 3/12 ms or 20/80 ms for insertion/removal.
// - Repeat field runs the pulse test 1, 2, 4 or 8 times.
// - Repeated pulse tests report the average of all results.
// - Pulse width 50/25/100/200 us; amplitude supply over 36/72/18/9.
// - Power control bit rising starts detection at once unless one is already running.
`timescale 1ns/100ps
module asd_top
  import asd_pkg::*;
#(
  parameter logic [DEB_CNT_W-1:0] DEB_INS_FAST_CYCLES = DEB_CNT_W'(DEB_INS_FAST_CYC),
  parameter logic [DEB_CNT_W-1:0] DEB_REM_FAST_CYCLES = DEB_CNT_W'(DEB_REM_FAST_CYC),
  parameter logic [DEB_CNT_W-1:0] DEB_INS_SLOW_CYCLES = DEB_CNT_W'(DEB_INS_SLOW_CYC),
  parameter logic [DEB_CNT_W-1:0] DEB_REM_SLOW_CYCLES = DEB_CNT_W'(DEB_REM_SLOW_CYC)
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Avalon-MM slave
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  // Jack front end pins
  input  wire logic        jackOpenRaw,
  input  wire logic [7:0]  contactKindRaw,
  input  wire logic [7:0]  probeSample,
  // Probe drive
  output logic             probePulse,
  output logic [1:0]       probeLevelSel,
  // Load and power control
  output logic [6:0]       loadConfig,
  output logic             loadForced,
  output logic             powerActive,
  output logic             jackInserted
);

  asd_probe_if probeBus ();

  asd_det_state_t det_reg;
  logic        ack_reg;
  logic [31:0] readData_reg;
  logic        override_reg;
  logic [6:0]  forcedCode_reg;
  logic [6:0]  detectedCode_reg;
  logic [7:0]  settings_reg;
  logic        powerCtrl_reg;
  logic [6:0]  loadConfig_reg;
  logic        jackSync1_reg;
  logic        jackSync2_reg;
  logic [7:0]  kindSync1_reg;
  logic [7:0]  kindSync2_reg;
  logic        jackStable;
  logic        jackStableDly_reg;
  logic        busReq;
  logic        aligned;
  logic [5:0]  regIndex;
  logic        wrStrobe;
  logic        accWrite;
  logic        overrideRelease;
  logic        powerRise;
  logic [7:0]  readValue;
  logic [6:0]  classCode;

  // Pin synchronisers
  always_ff @(posedge clk) begin
    if (reset) begin
      jackSync1_reg <= 1'b0;
      jackSync2_reg <= 1'b0;
      kindSync1_reg <= 8'h00;
      kindSync2_reg <= 8'h00;
    end else begin
      jackSync1_reg <= jackOpenRaw;
      jackSync2_reg <= jackSync1_reg;
      kindSync1_reg <= contactKindRaw;
      kindSync2_reg <= kindSync1_reg;
    end
  end

  // Jack sense comparator debounce
  asd_debounce #(
    .INS_FAST (DEB_INS_FAST_CYCLES),
    .REM_FAST (DEB_REM_FAST_CYCLES),
    .INS_SLOW (DEB_INS_SLOW_CYCLES),
    .REM_SLOW (DEB_REM_SLOW_CYCLES)
  ) u_debounce (
    .clk         (clk),
    .reset       (reset),
    .rawLevel    (jackSync2_reg),
    .slowSel     (settings_reg[SET_DEB_BIT]),
    .stableLevel (jackStable)
  );

  // Pulse probe sequencer
  asd_probe_seq u_probe (
    .clk         (clk),
    .reset       (reset),
    .probe       (probeBus.seq),
    .probeSample (probeSample),
    .probePulse  (probePulse)
  );

  // Bus decode; every access answers on its second cycle
  assign busReq      = read | write;
  assign aligned     = (address[1:0] == 2'h0);
  assign regIndex    = address[7:2];
  assign waitrequest = busReq & ~ack_reg;
  assign wrStrobe    = write & ack_reg & aligned & byteenable[0];
  assign accWrite    = wrStrobe && (regIndex == IDX_ACC_STATE);

  // Override released by a write
  assign overrideRelease = accWrite && !override_reg && writedata[ACC_OVERRIDE_BIT];

  // Detection needs a real 0 to 1 of the power bit
  assign powerRise = wrStrobe && (regIndex == IDX_POWER) && writedata[PWR_CTRL_BIT]
                     && !powerCtrl_reg;

  // Answer strobe
  always_ff @(posedge clk) begin
    if (reset) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= busReq & ~ack_reg;
    end
  end

  // Read mux
  always_comb begin
    readValue = 8'h00;
    if (!aligned) begin
      readValue = 8'h00;
    end else if (regIndex == IDX_ACC_STATE) begin
      readValue = {override_reg, override_reg ? detectedCode_reg : forcedCode_reg};
    end else if (regIndex == IDX_PROBE_SET) begin
      readValue = settings_reg & SET_WR_MASK;
    end else if (regIndex == IDX_SPARE) begin
      readValue = 8'h00;
    end else if (regIndex == IDX_POWER) begin
      readValue = {powerCtrl_reg, 7'h00};
    end else if (regIndex == IDX_STATUS) begin
      readValue = {jackStable, probeBus.busy || (det_reg != DET_IDLE), 6'h00};
    end else if (regIndex == IDX_PROBE_AVG) begin
      readValue = probeBus.average;
    end
  end

  // Read data caught in the wait cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      readData_reg <= 32'h0;
    end else if (read && !ack_reg) begin
      readData_reg <= {24'h0, readValue};
    end
  end

  // Accessory state register: override and written code
  always_ff @(posedge clk) begin
    if (reset) begin
      override_reg   <= ACC_OVERRIDE_RST;
      forcedCode_reg <= ACC_CODE_RST;
    end else if (accWrite) begin
      override_reg   <= writedata[ACC_OVERRIDE_BIT];
      forcedCode_reg <= writedata[6:0];
    end
  end

  // Probe settings; reserved bit 6 stays zero
  always_ff @(posedge clk) begin
    if (reset) begin
      settings_reg <= SET_RST;
    end else if (wrStrobe && regIndex == IDX_PROBE_SET) begin
      settings_reg <= writedata[7:0] & SET_WR_MASK;
    end
  end

  // Power control bit
  always_ff @(posedge clk) begin
    if (reset) begin
      powerCtrl_reg <= PWR_CTRL_RST;
    end else if (wrStrobe && regIndex == IDX_POWER) begin
      powerCtrl_reg <= writedata[PWR_CTRL_BIT];
    end
  end

  // Classify contact kinds and probe average
  function automatic logic [6:0] classify(input logic       inserted,
                                          input logic [7:0] kinds,
                                          input logic [7:0] avg);
    logic [1:0] tip;
    logic [1:0] ring1;
    logic [1:0] ring2;
    logic [1:0] sleeve;
    logic       swap;
    logic       tipOn;
    logic       ring1On;
    logic [1:0] monoOfs;
    logic [6:0] code;
    tip     = kinds[1:0];
    ring1   = kinds[3:2];
    ring2   = kinds[5:4];
    sleeve  = kinds[7:6];
    swap    = (ring2 == KIND_SPECIAL) && (sleeve == KIND_GROUND);
    tipOn   = (tip == KIND_LOAD);
    ring1On = (ring1 == KIND_LOAD);
    monoOfs = 2'h0;
    code    = CODE_UNSUPPORTED;
    if (!inserted) begin
      code = CODE_NONE;
    end else if (swap || (ring2 == KIND_GROUND && sleeve == KIND_SPECIAL)) begin
      if (tipOn && ring1On) begin
        code = swap ? CODE_HS_STEREO_SWAP : CODE_HS_STEREO;
      end else if (tipOn) begin
        if (ring1 == KIND_GROUND) begin
          monoOfs = 2'h0;
        end else if (ring1 == KIND_SPECIAL) begin
          monoOfs = 2'h1;
        end else begin
          monoOfs = 2'h2;
        end
        code = CODE_MONO_BASE + 7'({monoOfs, swap});
      end
    end else if (ring2 == KIND_GROUND && sleeve == KIND_GROUND) begin
      if (avg >= LINEOUT_THRESH) begin
        if (tipOn && ring1On) begin
          code = CODE_LO_STEREO;
        end else if (ring1On) begin
          code = CODE_LO_RIGHT;
        end else if (tipOn) begin
          code = CODE_LO_LEFT;
        end
      end else begin
        if (tipOn && ring1On) begin
          code = CODE_HP_STEREO;
        end else if (tipOn) begin
          code = CODE_HP_LEFT;
        end else if (ring1On) begin
          code = CODE_HP_RIGHT;
        end
      end
    end
    return code;
  endfunction

  assign classCode = classify(jackStable, kindSync2_reg, probeBus.average);

  // Detection sequence; a rise while busy is ignored
  always_ff @(posedge clk) begin
    if (reset) begin
      det_reg <= DET_IDLE;
    end else begin
      case (det_reg)
        DET_IDLE: begin
          if (powerRise) begin
            det_reg <= jackStable ? DET_PROBE : DET_CLASSIFY;
          end
        end
        DET_PROBE: begin
          if (probeBus.done) begin
            det_reg <= DET_CLASSIFY;
          end
        end
        DET_CLASSIFY: det_reg <= DET_IDLE;
        default:      det_reg <= DET_IDLE;
      endcase
    end
  end

  // Probe start and settings
  assign probeBus.start     = (det_reg == DET_IDLE) && powerRise && jackStable;
  assign probeBus.repeatSel = settings_reg[SET_REP_LSB +: 2];
  assign probeBus.widthSel  = settings_reg[SET_PW_LSB +: 2];

  // Removal edge of the debounced jack
  always_ff @(posedge clk) begin
    if (reset) begin
      jackStableDly_reg <= 1'b0;
    end else begin
      jackStableDly_reg <= jackStable;
    end
  end

  // Detected code; release keeps the written code
  always_ff @(posedge clk) begin
    if (reset) begin
      detectedCode_reg <= ACC_CODE_RST;
    end else if (overrideRelease) begin
      detectedCode_reg <= forcedCode_reg;
    end else if (det_reg == DET_CLASSIFY && powerCtrl_reg) begin
      detectedCode_reg <= classCode;
    end else if (jackStableDly_reg && !jackStable) begin
      detectedCode_reg <= CODE_NONE;
    end
  end

  // Load follows forced or detected code
  always_ff @(posedge clk) begin
    if (reset) begin
      loadConfig_reg <= ACC_CODE_RST;
    end else begin
      loadConfig_reg <= override_reg ? detectedCode_reg : forcedCode_reg;
    end
  end

  // Outputs
  assign readdata      = readData_reg;
  assign loadConfig    = loadConfig_reg;
  assign loadForced    = ~override_reg;
  assign probeLevelSel = settings_reg[SET_AMP_LSB +: 2];
  assign powerActive   = powerCtrl_reg;
  assign jackInserted  = jackStable;

endmodule

// ---- asd_assertions.sv ----
`timescale 1ns/100ps
module asd_assertions
  import asd_pkg::*;
#(
  parameter logic [DEB_CNT_W-1:0] INS_F = 21'h14,
  parameter logic [DEB_CNT_W-1:0] REM_F = 21'h28,
  parameter logic [DEB_CNT_W-1:0] INS_S = 21'h3c,
  parameter logic [DEB_CNT_W-1:0] REM_S = 21'h50
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // Register bus
  input wire logic [7:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  // Jack and load side
  input wire logic        jackOpenRaw,
  input wire logic        probePulse,
  input wire logic [1:0]  probeLevelSel,
  input wire logic [6:0]  loadConfig,
  input wire logic        loadForced,
  input wire logic        powerActive,
  input wire logic        jackInserted
);
  logic [7:0]           setReg;
  logic [15:0]          hiCnt;
  logic [15:0]          wCyc;
  logic [DEB_CNT_W-1:0] rawCnt;
  logic                 rawLast;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Settings shadow
  always_ff @(posedge clk) begin
    if (reset) setReg <= SET_RST;
    else if (write && !waitrequest && address == 8'h68) setReg <= writedata[7:0];
  end
  // Burst length; cycles since pin moved
  always_ff @(posedge clk) begin
    hiCnt <= (reset || !probePulse) ? 16'h0 : hiCnt + 16'h1;
    rawLast <= jackOpenRaw;
    rawCnt <= (reset || jackOpenRaw != rawLast) ? '0 : rawCnt + 1'b1;
  end
  // Width table is not monotonic
  assign wCyc = setReg[3:2] == 2'h0 ? 16'(PW_A_CYC) : setReg[3:2] == 2'h1 ? 16'(PW_B_CYC)
              : setReg[3:2] == 2'h2 ? 16'(PW_C_CYC) : 16'(PW_D_CYC);
  sequence s_wr(a);
    write && !waitrequest && address == a;
  endsequence
  sequence s_rd(a);
    read && !waitrequest && address == a;
  endsequence
  a_force_load: assert property (s_wr(8'h64) ##0 !writedata[7] |=> loadForced ##1
    loadConfig == $past(writedata[6:0], 2)) else $error("force lost");
  a_release_hold: assert property (s_wr(8'h64) ##0 writedata[7] && loadForced
    |=> (!loadForced && $stable(loadConfig))[*2]) else $error("release moved");
  a_show_code: assert property (s_rd(8'h64) ##0 $stable(loadConfig)
    |-> readdata[7:0] == {!loadForced, loadConfig}) else $error("state readback wrong");
  a_level_sel: assert property (s_wr(8'h68) |=>
    probeLevelSel == $past(writedata[1:0])) else $error("level select wrong");
  a_burst_len: assert property ($fell(probePulse) |->
    hiCnt == (wCyc << setReg[5:4])) else $error("burst length");
  a_power_probe: assert property (s_wr(8'h74) ##0 writedata[7] && !powerActive
    && jackInserted |=> probePulse) else $error("no probe");
  a_empty_code: assert property (s_wr(8'h74) ##0 writedata[7] && !powerActive
    && !jackInserted && !loadForced |=> ##[1:3] loadConfig == CODE_NONE)
    else $error("empty code");
  a_reserved_zero: assert property (read && !waitrequest |-> readdata[31:8] == 24'h0
    && !(address == 8'h6c && readdata[7:0] != 8'h0) && !(address == 8'h68 && readdata[6]))
    else $error("reserved set");
  a_ins_deb: assert property ($rose(jackInserted) |-> rawCnt + 2 >= (setReg[7] ? INS_S : INS_F)
    && rawCnt <= (setReg[7] ? INS_S : INS_F) + 5) else $error("insertion debounce wrong");
  a_rem_deb: assert property ($fell(jackInserted) |-> rawCnt + 2 >= (setReg[7] ? REM_S : REM_F)
    && rawCnt <= (setReg[7] ? REM_S : REM_F) + 5) else $error("removal debounce wrong");
endmodule
bind asd_top asd_assertions #(.INS_F(DEB_INS_FAST_CYCLES), .REM_F(DEB_REM_FAST_CYCLES),
  .INS_S(DEB_INS_SLOW_CYCLES), .REM_S(DEB_REM_SLOW_CYCLES)) uChk (
  .clk(clk), .reset(reset), .address(address), .read(read), .write(write),
  .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
  .jackOpenRaw(jackOpenRaw), .probePulse(probePulse), .probeLevelSel(probeLevelSel),
  .loadConfig(loadConfig), .loadForced(loadForced), .powerActive(powerActive),
  .jackInserted(jackInserted));

// ---- asd_jack_model.sv ----
`timescale 1ns/100ps
module asd_jack_model (
  // Plug chosen by the bench
  input  wire logic       present,
  input  wire logic [7:0] kinds,
  input  wire logic [7:0] base,
  // Device side
  input  wire logic       probePulse,
  output logic            jackOpenRaw,
  output logic [7:0]      contactKindRaw,
  output logic [7:0]      probeSample
);
  // Empty jack floats every contact
  assign jackOpenRaw    = present;
  assign contactKindRaw = present ? kinds : 8'h00;
  // Inverse off the pulse, so a mistimed sample shows
  assign probeSample    = probePulse ? base : ~base;
endmodule

// ---- testbench.sv ----
`timescale 1ns/100ps
module testbench;
  import asd_pkg::*;
  logic        clk, reset, read, write, present, waitrequest, jackOpenRaw;
  logic        probePulse, loadForced, powerActive, jackInserted;
  logic [7:0]  address, kinds, base, b, contactKindRaw, probeSample;
  logic [31:0] writedata, readdata, rdVal, rnd;
  logic [1:0]  probeLevelSel, rep, wSel;
  logic [6:0]  loadConfig, code;
  int          badCount, totalChecks, hiCycles, sum;
  int          q[$];
  // Contact patterns; codes for low and high probe averages
  logic [7:0]  kt[15] = '{8'hda, 8'h7a, 8'hd6, 8'h76, 8'hde, 8'h7e, 8'hd2, 8'h72,
                          8'h5a, 8'h5a, 8'h52, 8'h52, 8'h58, 8'h58, 8'h50};
  logic [6:0]  ht[15] = '{7'h01, 7'h02, 7'h0a, 7'h0b, 7'h0c, 7'h0d, 7'h0e, 7'h0f,
                          7'h10, 7'h10, 7'h11, 7'h11, 7'h12, 7'h12, 7'h1f};
  logic [6:0]  lt[7] = '{7'h1a, 7'h1a, 7'h1c, 7'h1c, 7'h1b, 7'h1b, 7'h1f};
  logic [11:0] wt[4] = '{PW_A_CYC, PW_B_CYC, PW_C_CYC, PW_D_CYC};
  asd_top #(.DEB_INS_FAST_CYCLES(21'h14), .DEB_REM_FAST_CYCLES(21'h28),
    .DEB_INS_SLOW_CYCLES(21'h3c), .DEB_REM_SLOW_CYCLES(21'h50)) dut (
    .clk(clk), .reset(reset), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(4'h1), .readdata(readdata),
    .waitrequest(waitrequest), .jackOpenRaw(jackOpenRaw),
    .contactKindRaw(contactKindRaw), .probeSample(probeSample), .probePulse(probePulse),
    .probeLevelSel(probeLevelSel), .loadConfig(loadConfig), .loadForced(loadForced),
    .powerActive(powerActive), .jackInserted(jackInserted));
  asd_jack_model jack (.present(present), .kinds(kinds), .base(base),
    .probePulse(probePulse), .jackOpenRaw(jackOpenRaw),
    .contactKindRaw(contactKindRaw), .probeSample(probeSample));
  // Clock, 50 ns period
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Probe cycles this run
  always @(posedge clk) if (probePulse === 1'b1) hiCycles++;
  // Watchdog
  initial begin
    repeat (90000) @(posedge clk);
    badCount++;
    reportAndStop();
  end
  function automatic logic [31:0] nextRnd(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    totalChecks++;
    if (got !== exp) begin
      badCount++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  // One access, held until waitrequest low
  task automatic bus(logic wr, logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    address <= a;
    writedata <= {24'h0, d};
    read <= !wr;
    write <= wr;
    do @(posedge clk); while (waitrequest !== 1'b0);
    rdVal = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic rdChk(logic [7:0] a, logic [7:0] e);
    bus(1'b0, a, 8'h00);
    check($sformatf("reg %h", a), {24'h0, e}, rdVal);
  endtask
  // Move plug; count edges to debounced flag
  task automatic deb(logic lvl, int lim);
    int n;
    n = 0;
    present <= lvl;
    while (jackInserted !== lvl && n < 400) begin
      @(posedge clk);
      n++;
    end
    check("debounce", 1, n >= lim && n <= lim + 6);
  endtask
  // Power bit low then high; wait out busy
  task automatic detect();
    bus(1'b1, 8'h74, 8'h00);
    hiCycles = 0;
    bus(1'b1, 8'h74, 8'h80);
    do bus(1'b0, 8'hc0, 8'h00); while (rdVal[6] !== 1'b0);
    check("power", 1, powerActive);
    repeat (4) @(posedge clk);
  endtask
  task automatic reportAndStop();
    $display("checks %0d mismatches %0d", totalChecks, badCount);
    if (badCount == 0 && totalChecks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    reset = 1'b1;
    read = 1'b0;
    write = 1'b0;
    present = 1'b0;
    address = 8'h00;
    writedata = 32'h0;
    kinds = 8'h00;
    base = 8'h00;
    rnd = 32'hec86d29a;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    rdChk(8'h64, 8'h80);
    rdChk(8'h68, 8'h15);
    rdChk(8'h6c, 8'h00);
    check("level", 2'h1, probeLevelSel);
    $display("reset done");
    // Random settings; reserved bit reads zero
    repeat (4) begin
      rnd = nextRnd(rnd);
      bus(1'b1, 8'h68, rnd[7:0]);
      rdChk(8'h68, rnd[7:0] & 8'hbf);
      check("level", rnd[1:0], probeLevelSel);
    end
    bus(1'b1, 8'h6c, 8'hff);
    rdChk(8'h6c, 8'h00);
    rdChk(8'h7c, 8'h00);
    $display("settings done");
    code = rnd[14:8];
    bus(1'b1, 8'h64, {1'b0, code});
    repeat (2) @(posedge clk);
    check("forced load", {1'b1, code}, {loadForced, loadConfig});
    rdChk(8'h64, {1'b0, code});
    bus(1'b1, 8'h64, 8'h80);
    repeat (2) @(posedge clk);
    check("released load", {1'b0, code}, {loadForced, loadConfig});
    rdChk(8'h64, {1'b1, code});
    detect();
    rdChk(8'h64, 8'h80);
    check("probe cycles", 0, hiCycles);
    $display("override done");
    bus(1'b1, 8'h68, 8'h95);
    deb(1'b1, 60);
    deb(1'b0, 80);
    bus(1'b1, 8'h68, 8'h15);
    deb(1'b1, 20);
    $display("debounce done");
    // Each pattern, repeat and width
    for (int i = 0; i < 15; i++) begin
      rnd = nextRnd(rnd);
      rep = 2'(3 - i % 4);
      wSel = 2'(i % 4);
      b = {i[0], rnd[6:0]};
      kinds <= kt[i];
      base <= b;
      bus(1'b1, 8'h68, {2'h0, rep, wSel, rnd[9:8]});
      detect();
      q = {};
      repeat (1 << rep) q.push_back(b);
      sum = 0;
      foreach (q[k]) sum += q[k];
      code = b[7] && i > 7 ? lt[i-8] : ht[i];
      check("probe cycles", 32'(wt[wSel]) << rep, hiCycles);
      rdChk(8'hc4, 8'(sum >> rep));
      rdChk(8'h64, {1'b1, code});
      check("load", code, loadConfig);
      $display("accessory %0d done", i);
    end
    deb(1'b0, 40);
    repeat (4) @(posedge clk);
    check("removal load", 7'h00, loadConfig);
    $display("removal done");
    reportAndStop();
  end
endmodule
